// File: pkg/spf_pkg.sv
// constants, types and timing for the self-programming flash control
package spf_pkg;
    localparam int CSR_W = 8;
    localparam int PTR_W = 16;
    localparam int BIT_SIG = 5;
    localparam int BIT_CLR = 4;
    localparam int BIT_FUSE_LOCK_READ_SELECT = 3;
    localparam int BIT_PAGE_WRITE_CMD = 2;
    localparam int BIT_PAGE_ERASE_CMD = 1;
    localparam int BIT_EN = 0;
    localparam int DEBUG_FUSE_BIT = 6;
    localparam int SIG_INDEX_W = 6;

    typedef struct packed {
        logic rsvd7;
        logic rsvd6;
        logic signature_read_select;
        logic buffer_clear;
        logic fuse_lock_read_select;
        logic page_write_cmd;
        logic page_erase_cmd;
        logic store_enable;
    } spf_csr_t;

    localparam spf_csr_t CSR_RESET = 8'h00;
    localparam logic [1:0] RSVD_READ = 2'h0;

    // store window in cycles after the write; loads use the first three of them
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_LAST = 3'h2;
    localparam logic [2:0] WIN_LAST = 3'h1;

    localparam logic [1:0] LOCK_ERASED = 2'h3;
    localparam logic [5:0] LOCK_UNUSED_BITS = 6'h3f;
    localparam logic [1:0] FSEL_LOW = 2'h0;
    localparam logic [1:0] FSEL_LOCK = 2'h1;
    localparam logic [1:0] FSEL_EXT = 2'h2;
    localparam logic [1:0] FSEL_HIGH = 2'h3;
    localparam logic [15:0] BUF_ERASED = 16'hffff;

    // timing: 10 MHz system clock, oscillator-derived 1 us timebase
    localparam int CLK_PERIOD_NS = 100;
    localparam int RC_TICK_NS = 1000;
    localparam int RC_TICK_CYCLES = (RC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_MIN_US = 3700;
    localparam int PROG_MAX_US = 4500;
    localparam int PROG_MIN_TICKS = (PROG_MIN_US * 1000 + RC_TICK_NS - 1) / RC_TICK_NS;
    localparam int PROG_MIN_CYCLES = (PROG_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_MAX_CYCLES = (PROG_MAX_US * 1000) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_WRITE = 2'b10,
        ST_LOCK = 2'b11
    } spf_state_t;

    typedef struct packed {
        logic no_prog;
        logic no_verify;
        logic fuse_locked;
        logic debug_link_en;
        logic debug_read_en;
    } spf_prot_t;
endpackage : spf_pkg

// File: hw/spf_prog_timer.sv
// programming-time timer driven by a divided oscillator tick
`timescale 1ns/1ps
module spf_prog_timer
    import spf_pkg::*;
#(
    parameter int TICK_CYCLES = RC_TICK_CYCLES,
    parameter int PROG_TICKS = PROG_MIN_TICKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    output logic done,
    output logic running
);
    logic [15:0] div_cnt;
    logic [15:0] tick_cnt;
    logic tick;

    // divider stands in for the calibrated oscillator timebase
    assign tick = running && (div_cnt == 16'(TICK_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!resetn || start || tick) begin
            div_cnt <= 16'h0000;
        end else if (running) begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            running <= 1'b0;
            tick_cnt <= 16'h0000;
            done <= 1'b0;
        end else if (start) begin
            running <= 1'b1;
            tick_cnt <= 16'h0000;
            done <= 1'b0;
        end else if (tick && tick_cnt == 16'(PROG_TICKS - 1)) begin
            running <= 1'b0;
            done <= 1'b1;
        end else begin
            done <= 1'b0;
            if (tick) begin
                tick_cnt <= tick_cnt + 16'h0001;
            end
        end
    end
endmodule : spf_prog_timer

// File: hw/spf_flash_ctrl.sv
// self-programming control: control/status register, page buffer, lock bits
`timescale 1ns/1ps
// Notes on behaviour
// - control bits 7:6 always read zero
// - signature read returns table byte at pointer
// - buffer clear bit empties the page buffer
// - fuse/lock read selected by pointer low bits
// - page write programs buffer into pointer page
// - page write bit clears on finish or timeout
// - page erase erases page at pointer
// - page erase bit clears on finish or timeout
// - CPU stalled during erase and write
// - store enable opens four-cycle store window
// - plain store loads word into buffer
// - store enable clears after store or timeout
// - store enable stays set while busy
// - operations last between 3.7 and 4.5 ms
// - reset lets a running write finish
// - two lock bits, only chip erase sets
// - both unprogrammed means no protection
// - mode 2 blocks programming, fuses, debug link
// - mode 3 also blocks external verification
// - debug fuse keeps memory readable over link
// - EEPROM write blocks programming and fuse reads
module spf_flash_ctrl
    import spf_pkg::*;
#(
    parameter int PAGE_WORDS = 32,
    parameter int PAGES = 128,
    parameter int TICK_CYCLES = RC_TICK_CYCLES,
    parameter int PROG_TICKS = PROG_MIN_TICKS
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CSR_WE,
    input wire logic [CSR_W-1:0] CSR_WDATA,
    output logic [CSR_W-1:0] CSR_RDATA,
    input wire logic STORE_INSTR,
    input wire logic LOAD_INSTR,
    input wire logic [PTR_W-1:0] POINTER,
    input wire logic [15:0] STORE_DATA,
    output logic LOAD_HIT,
    output logic [7:0] LOAD_DATA,
    output logic CPU_STALL,
    input wire logic EEPROM_BUSY,
    input wire logic [7:0] FUSE_LOW,
    input wire logic [7:0] FUSE_HIGH,
    input wire logic [7:0] FUSE_EXT,
    output logic [SIG_INDEX_W-1:0] SIG_INDEX,
    input wire logic [7:0] SIG_BYTE,
    input wire logic [1:0] LOCK_NV,
    output logic LOCK_WE,
    output logic [1:0] LOCK_WDATA,
    output logic FLASH_ERASE,
    output logic FLASH_WE,
    output logic [$clog2(PAGES)-1:0] FLASH_PAGE,
    output logic [$clog2(PAGE_WORDS)-1:0] FLASH_WORD,
    output logic [15:0] FLASH_WDATA,
    output spf_prot_t PROT
);
    localparam int WORD_W = $clog2(PAGE_WORDS);
    localparam int PAGE_W = $clog2(PAGES);

    spf_csr_t csr;
    spf_state_t state;
    logic [2:0] win;
    logic [15:0] page_buf [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] written;
    logic [WORD_W:0] wr_idx;
    logic eep_q;
    logic busy;
    logic keep_n;
    logic accept_wr;
    logic store_ok;
    logic store_go;
    logic load_go;
    logic start_op;
    logic op_done;
    logic buf_clear;
    logic [WORD_W-1:0] fill_idx;
    logic [7:0] fuse_mux;

    assign busy = (state != ST_IDLE);
    // reset is held off from the operation logic while flash is being written
    assign keep_n = RESETN || busy;
    assign CPU_STALL = busy;
    assign accept_wr = CSR_WE && !busy && !EEPROM_BUSY;
    assign store_ok = csr.store_enable && (win != 3'h0) && !busy;
    assign store_go = STORE_INSTR && store_ok && !EEPROM_BUSY;
    assign load_go = LOAD_INSTR && csr.store_enable && (win >= LOAD_LAST) && !busy
        && !EEPROM_BUSY && (csr.signature_read_select || csr.fuse_lock_read_select);
    assign start_op = store_go && (csr.page_erase_cmd || csr.page_write_cmd
        || csr.fuse_lock_read_select);
    assign fill_idx = POINTER[WORD_W:1];
    assign CSR_RDATA = {RSVD_READ, csr[5:0]};
    assign SIG_INDEX = POINTER[SIG_INDEX_W-1:0];

    // EEPROM write starting mid page-load throws the loaded data away
    assign buf_clear = (!RESETN && !busy) || (accept_wr && CSR_WDATA[BIT_CLR])
        || (op_done && state == ST_WRITE) || (EEPROM_BUSY && !eep_q);

    always_comb begin
        unique case (POINTER[1:0])
            FSEL_LOW: fuse_mux = FUSE_LOW;
            FSEL_LOCK: fuse_mux = {LOCK_UNUSED_BITS, LOCK_NV};
            FSEL_EXT: fuse_mux = FUSE_EXT;
            FSEL_HIGH: fuse_mux = FUSE_HIGH;
        endcase
    end

    // lock modes: 11 none, 10 no external programming, 00 also no verify
    assign PROT.no_prog = (LOCK_NV != LOCK_ERASED);
    assign PROT.no_verify = (LOCK_NV == 2'b00);
    assign PROT.fuse_locked = !LOCK_NV[0];
    assign PROT.debug_link_en = !FUSE_HIGH[DEBUG_FUSE_BIT] && (LOCK_NV == LOCK_ERASED);
    // read-out stays open with the fuse programmed, whatever the lock state
    assign PROT.debug_read_en = !FUSE_HIGH[DEBUG_FUSE_BIT];

    spf_prog_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .PROG_TICKS(PROG_TICKS)
    ) u_timer (
        .clk(CLK),
        .resetn(keep_n),
        .start(start_op),
        .done(op_done),
        .running()
    );

    always_ff @(posedge CLK) begin
        if (!keep_n) begin
            csr <= CSR_RESET;
            win <= 3'h0;
        end else if (busy) begin
            if (op_done) begin
                csr <= CSR_RESET;
                win <= 3'h0;
            end
        end else if (accept_wr) begin
            csr <= CSR_WDATA[BIT_EN] ? {RSVD_READ, CSR_WDATA[5:0]} : CSR_RESET;
            win <= CSR_WDATA[BIT_EN] ? STORE_WINDOW : 3'h0;
        end else if (start_op) begin
            win <= 3'h0;
        end else if (store_go || load_go || win == WIN_LAST) begin
            csr <= CSR_RESET;
            win <= 3'h0;
        end else if (win != 3'h0) begin
            win <= win - 3'h1;
        end
    end

    always_ff @(posedge CLK) begin
        // reset in the else arm: unknown state at power-up still lands in idle
        if (keep_n) begin
            if (busy) begin
                if (op_done) begin
                    state <= ST_IDLE;
                end
            end else if (start_op) begin
                if (csr.page_erase_cmd) begin
                    state <= ST_ERASE;
                end else if (csr.page_write_cmd) begin
                    state <= ST_WRITE;
                end else begin
                    state <= ST_LOCK;
                end
            end
        end else begin
            state <= ST_IDLE;
        end
    end

    always_ff @(posedge CLK) begin
        if (!keep_n) begin
            FLASH_PAGE <= '0;
            FLASH_ERASE <= 1'b0;
            LOCK_WE <= 1'b0;
            LOCK_WDATA <= LOCK_ERASED;
        end else begin
            FLASH_ERASE <= start_op && csr.page_erase_cmd;
            LOCK_WE <= start_op && !csr.page_erase_cmd && !csr.page_write_cmd;
            if (start_op) begin
                // register pair data is ignored for erase and write
                FLASH_PAGE <= POINTER[WORD_W+PAGE_W:WORD_W+1];
                // AND keeps software from ever unprogramming a lock bit
                LOCK_WDATA <= LOCK_NV & STORE_DATA[1:0];
            end
        end
    end

    // page write streams the buffer out one word per cycle at the start
    always_ff @(posedge CLK) begin
        if (!keep_n) begin
            wr_idx <= '0;
            FLASH_WE <= 1'b0;
            FLASH_WORD <= '0;
            FLASH_WDATA <= 16'h0000;
        end else if (start_op) begin
            wr_idx <= '0;
            FLASH_WE <= 1'b0;
        end else if (state == ST_WRITE && wr_idx < (WORD_W+1)'(PAGE_WORDS)) begin
            FLASH_WE <= 1'b1;
            FLASH_WORD <= wr_idx[WORD_W-1:0];
            FLASH_WDATA <= page_buf[wr_idx[WORD_W-1:0]];
            wr_idx <= wr_idx + (WORD_W+1)'(1);
        end else begin
            FLASH_WE <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            eep_q <= 1'b0;
        end else begin
            eep_q <= EEPROM_BUSY;
        end
    end

    // each word may be loaded once until the buffer is cleared
    for (genvar g = 0; g < PAGE_WORDS; g++) begin : g_buf
        always_ff @(posedge CLK) begin
            if (buf_clear) begin
                page_buf[g] <= BUF_ERASED;
                written[g] <= 1'b0;
            end else if (store_go && !start_op && !csr.buffer_clear
                && fill_idx == WORD_W'(g) && !written[g]) begin
                page_buf[g] <= STORE_DATA;
                written[g] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            LOAD_HIT <= 1'b0;
            LOAD_DATA <= 8'h00;
        end else begin
            LOAD_HIT <= load_go;
            if (load_go) begin
                LOAD_DATA <= csr.signature_read_select ? SIG_BYTE : fuse_mux;
            end
        end
    end

    // helper: cycles spent in the current operation
    logic [16:0] op_cyc;
    always_ff @(posedge CLK) begin
        if (!busy) begin
            op_cyc <= 17'h0_0000;
        end else begin
            op_cyc <= op_cyc + 17'h0_0001;
        end
    end

    chk_rsvd_zero: assert property (@(posedge CLK) CSR_RDATA[7:6] == RSVD_READ)
        else $error("reserved control bits read nonzero");
    chk_sig_load: assert property (@(posedge CLK) disable iff (!RESETN)
        load_go && csr.signature_read_select |=> LOAD_HIT && LOAD_DATA == $past(SIG_BYTE))
        else $error("signature read returned wrong byte");
    chk_buf_clear: assert property (@(posedge CLK) disable iff (!RESETN)
        accept_wr && CSR_WDATA[BIT_CLR] |=> written == '0)
        else $error("buffer not cleared");
    chk_lock_read: assert property (@(posedge CLK) disable iff (!RESETN)
        load_go && !csr.signature_read_select && POINTER[1:0] == FSEL_LOCK
        |=> LOAD_DATA == {LOCK_UNUSED_BITS, $past(LOCK_NV)})
        else $error("lock bit read wrong");
    chk_write_start: assert property (@(posedge CLK) disable iff (!RESETN)
        start_op && csr.page_write_cmd |=> state == ST_WRITE ##1 FLASH_WE)
        else $error("page write did not start");
    chk_win_expire: assert property (@(posedge CLK) disable iff (!RESETN)
        (accept_wr && CSR_WDATA[BIT_EN] && !CSR_WDATA[BIT_PAGE_ERASE_CMD]
        ##1 (!STORE_INSTR && !LOAD_INSTR && !CSR_WE) [*4]) |=> csr == CSR_RESET)
        else $error("store window did not expire after four cycles");
    chk_stall_op: assert property (@(posedge CLK) disable iff (!RESETN)
        start_op && csr.page_erase_cmd |=> CPU_STALL [*8])
        else $error("cpu not stalled during erase");
    chk_en_busy: assert property (@(posedge CLK) disable iff (!RESETN)
        busy && !op_done |=> csr.store_enable || !busy)
        else $error("store enable dropped while busy");
    chk_op_time: assert property (@(posedge CLK) disable iff (!RESETN)
        op_done |-> op_cyc >= 17'(PROG_TICKS * TICK_CYCLES)
        && op_cyc <= 17'(PROG_TICKS * TICK_CYCLES + 2))
        else $error("operation time out of range");
    chk_reset_hold: assert property (@(posedge CLK)
        !RESETN && busy && !op_done |=> state == $past(state))
        else $error("reset aborted a flash write");
    chk_eep_block: assert property (@(posedge CLK) disable iff (!RESETN)
        EEPROM_BUSY && !busy |=> !busy && !LOAD_HIT)
        else $error("flash access during EEPROM write");
    chk_late_store: assert property (@(posedge CLK) disable iff (!RESETN)
        STORE_INSTR && win == 3'h0 && !busy && !accept_wr |=> !busy && $stable(written))
        else $error("store outside window had effect");

    cov_erase: cover property (@(posedge CLK) disable iff (!RESETN)
        start_op && csr.page_erase_cmd);
    cov_write: cover property (@(posedge CLK) disable iff (!RESETN) state == ST_WRITE && op_done);
    cov_sig: cover property (@(posedge CLK) disable iff (!RESETN) load_go && csr.signature_read_select);
endmodule : spf_flash_ctrl

// File: tb/spf_cpu_model.sv
// cpu core model: register writes, store and load instructions
`timescale 1ns/1ps
module spf_cpu_model
    import spf_pkg::*;
(
    input wire logic clk,
    input wire logic stall,
    output logic csr_we,
    output logic [CSR_W-1:0] csr_wdata,
    output logic store,
    output logic load,
    output logic [PTR_W-1:0] ptr,
    output logic [15:0] sdata
);
    initial begin
        csr_we = 1'b0;
        csr_wdata = 8'h00;
        store = 1'b0;
        load = 1'b0;
        ptr = 16'h0000;
        sdata = 16'h0000;
    end

    // a halted core decodes nothing, so wait out a stall of up to 64 cycles first
    task automatic csr_wr(input logic [7:0] d);
        @(negedge clk);
        for (int i = 0; i < 64 && stall; i++) @(negedge clk);
        csr_we = 1'b1;
        csr_wdata = d;
        @(negedge clk);
        csr_we = 1'b0;
    endtask : csr_wr

    // pointer and data stay put after the instruction, like core registers
    task automatic instr(input logic st, input logic [15:0] p, input logic [15:0] d);
        @(negedge clk);
        ptr = p;
        sdata = d;
        store = st;
        load = !st;
        @(negedge clk);
        store = 1'b0;
        load = 1'b0;
    endtask : instr
endmodule : spf_cpu_model

// File: tb/tb.sv
// self-checking bench for the self-programming flash control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb;
    import spf_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic CSR_WE, STORE_INSTR, LOAD_INSTR, LOAD_HIT, CPU_STALL, LOCK_WE;
    logic FLASH_ERASE, FLASH_WE;
    logic EEPROM_BUSY = 1'b0;
    logic [7:0] CSR_WDATA, CSR_RDATA, LOAD_DATA, FUSE_LOW, FUSE_HIGH, FUSE_EXT, SIG_BYTE;
    logic [15:0] POINTER, STORE_DATA, FLASH_WDATA;
    logic [5:0] SIG_INDEX;
    logic [1:0] LOCK_NV = 2'b11;
    logic [1:0] LOCK_WDATA, lock_got;
    logic [6:0] FLASH_PAGE, pg, er_page, wr_page;
    logic [4:0] FLASH_WORD;
    spf_prot_t PROT;
    logic [15:0] got [32];
    logic [15:0] exp [32];
    int fails = 0;
    int n_checks = 0;
    int n_we, n_er, n_hit;
    logic [7:0] ld;
    // operation must outlast the 32-word page stream
    localparam int TB_TICK = 4;
    localparam int TB_PROG = 10;

    always #50 CLK = ~CLK;
    // arbitrary table contents, distinct per index
    assign SIG_BYTE = {2'b01, SIG_INDEX} ^ 8'h5a;

    spf_cpu_model i_cpu (.clk(CLK), .stall(CPU_STALL), .csr_we(CSR_WE), .csr_wdata(CSR_WDATA),
        .store(STORE_INSTR), .load(LOAD_INSTR), .ptr(POINTER), .sdata(STORE_DATA));

    spf_flash_ctrl #(.TICK_CYCLES(TB_TICK), .PROG_TICKS(TB_PROG)) i_spf_flash_ctrl (.CLK(CLK),
        .RESETN(RESETN), .CSR_WE(CSR_WE), .CSR_WDATA(CSR_WDATA), .CSR_RDATA(CSR_RDATA),
        .STORE_INSTR(STORE_INSTR), .LOAD_INSTR(LOAD_INSTR), .POINTER(POINTER),
        .STORE_DATA(STORE_DATA), .LOAD_HIT(LOAD_HIT), .LOAD_DATA(LOAD_DATA),
        .CPU_STALL(CPU_STALL), .EEPROM_BUSY(EEPROM_BUSY), .FUSE_LOW(FUSE_LOW),
        .FUSE_HIGH(FUSE_HIGH), .FUSE_EXT(FUSE_EXT), .SIG_INDEX(SIG_INDEX),
        .SIG_BYTE(SIG_BYTE), .LOCK_NV(LOCK_NV), .LOCK_WE(LOCK_WE), .LOCK_WDATA(LOCK_WDATA),
        .FLASH_ERASE(FLASH_ERASE), .FLASH_WE(FLASH_WE), .FLASH_PAGE(FLASH_PAGE),
        .FLASH_WORD(FLASH_WORD), .FLASH_WDATA(FLASH_WDATA), .PROT(PROT));

    always @(posedge CLK) begin
        if (FLASH_WE) begin
            got[FLASH_WORD] <= FLASH_WDATA;
            wr_page <= FLASH_PAGE;
            n_we <= n_we + 1;
        end
        if (FLASH_ERASE) begin
            er_page <= FLASH_PAGE;
            n_er <= n_er + 1;
        end
        if (LOCK_WE) lock_got <= LOCK_WDATA;
        if (LOAD_HIT) begin
            ld <= LOAD_DATA;
            n_hit <= n_hit + 1;
        end
    end

    function automatic logic [7:0] fsel(input logic [1:0] s);
        case (s)
            2'd0: return FUSE_LOW;
            2'd1: return {6'h3f, LOCK_NV};
            2'd2: return FUSE_EXT;
            default: return FUSE_HIGH;
        endcase
    endfunction : fsel

    task automatic end_sim();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    // one timed operation; optional reset pulse while it runs
    task automatic run_op(input logic [7:0] c, input logic [15:0] p, input logic [15:0] d,
        input bit rst);
        int n;
        n = 0;
        i_cpu.csr_wr(c);
        i_cpu.instr(1'b1, p, d);
        @(negedge CLK);
        `CHK("stall", 1'b1, CPU_STALL)
        `CHK("busy csr", c, CSR_RDATA)
        while (CPU_STALL === 1'b1 && n < 80) begin
            n++;
            if (rst && n == 2) RESETN = 1'b0;
            if (n == 4) RESETN = 1'b1;
            @(negedge CLK);
        end
        if (n >= 80) begin
            fails++;
            end_sim();
        end
        `CHK("op cycles", 1'b1, n >= TB_PROG * TB_TICK && n <= TB_PROG * TB_TICK + 3)
        `CHK("csr done", 8'h00, CSR_RDATA)
    endtask : run_op

    task automatic page_wr();
        n_we = 0;
        run_op(8'h05, {3'h0, pg, 6'h00}, 16'h0000, 1'b0);
        `CHK("we count", 32, n_we)
        `CHK("wr page", pg, wr_page)
        for (int w = 0; w < 32; w++) `CHK("word", exp[w], got[w])
    endtask : page_wr

    task automatic rd(input logic [7:0] c, input logic [15:0] p, input logic [7:0] e, int h);
        n_hit = 0;
        i_cpu.csr_wr(c);
        i_cpu.instr(1'b0, p, 16'h0000);
        repeat (2) @(negedge CLK);
        `CHK("hits", h, n_hit)
        if (h == 1) `CHK("load", e, ld)
    endtask : rd

    initial begin
        void'($urandom(70));
        FUSE_LOW = $urandom;
        FUSE_HIGH = $urandom;
        FUSE_EXT = $urandom;
        repeat (16) @(negedge CLK);
        RESETN = 1'b1;
        `CHK("csr reset", 8'h00, CSR_RDATA)
        i_cpu.csr_wr(8'hc1);
        @(negedge CLK);
        `CHK("csr rsvd", 8'h01, CSR_RDATA)
        repeat (4) @(negedge CLK);
        `CHK("csr expiry", 8'h00, CSR_RDATA)
        pg = $urandom;
        for (int w = 0; w < 32; w++) begin
            exp[w] = (w % 3 == 0) ? 16'hffff : 16'($urandom);
            if (w % 3 != 0) begin
                i_cpu.csr_wr(8'h01);
                i_cpu.instr(1'b1, {3'h0, pg, 5'(w), 1'($urandom)}, exp[w]);
            end
        end
        i_cpu.csr_wr(8'h01);
        repeat (5) @(negedge CLK);
        i_cpu.instr(1'b1, {3'h0, pg, 6'h00}, 16'h1234);
        page_wr();
        // buffer empties after a page write, so everything reads erased next time
        for (int w = 0; w < 32; w++) exp[w] = 16'hffff;
        for (int w = 0; w < 4; w++) begin
            i_cpu.csr_wr(8'h01);
            i_cpu.instr(1'b1, {3'h0, pg, 5'(w), 1'b0}, 16'($urandom));
            exp[w] = 16'hffff;
        end
        i_cpu.csr_wr(8'h11);
        repeat (5) @(negedge CLK);
        page_wr();
        n_er = 0;
        run_op(8'h03, {3'h0, pg, 6'h00}, 16'($urandom), 1'b1);
        `CHK("erase n", 1, n_er)
        `CHK("erase page", pg, er_page)
        for (int k = 0; k < 2; k++) begin
            i_cpu.csr_wr(k == 0 ? 8'h05 : 8'h03);
            repeat (5) @(negedge CLK);
            `CHK("cmd expiry", 8'h00, CSR_RDATA)
        end
        for (int s = 0; s < 4; s++) begin
            FUSE_LOW = $urandom;
            FUSE_HIGH = $urandom;
            FUSE_EXT = $urandom;
            rd(8'h09, 16'(s), fsel(2'(s)), 1);
        end
        for (int k = 0; k < 3; k++) begin
            ld = 8'h00;
            pg = $urandom;
            rd(8'h21, {10'h000, pg[5:0]}, {2'b01, pg[5:0]} ^ 8'h5a, 1);
        end
        EEPROM_BUSY = 1'b1;
        rd(8'h09, 16'h0001, 8'h00, 0);
        EEPROM_BUSY = 1'b0;
        run_op(8'h09, 16'h0001, 16'h0002, 1'b0);
        `CHK("lock wdata", LOCK_NV & 2'b10, lock_got)
        for (int l = 0; l < 4; l++) begin
            for (int f = 0; f < 2; f++) begin
                @(negedge CLK);
                LOCK_NV = 2'(l);
                FUSE_HIGH[6] = 1'(f);
                #1;
                if (l != 1) `CHK("prot", {l != 3, l == 0, l != 3, l == 3 && f == 0, f == 0},
                    PROT)
            end
        end
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        end_sim();
    end
endmodule : tb
